// File: verilog/dbi_panel_strobe_timing.sv
// Parallel command-type panel bus strobe sequencer for write and read cycles
// Overview of operation
// - Write strobe stays low for the write-strobe-low count, 1 to 31.
// - Write strobe high between strobes lasts write-setup plus hold counts.
// - Address/command select is stable write-setup cycles before write strobe falls.
// - Data, select and chip select stay unchanged hold cycles after write strobe.
// - Write data driven write-setup plus strobe-low cycles before strobe rises.
// - Chip select asserted write-setup plus strobe-low cycles before strobe rises.
// - Read strobe stays low for the read-strobe-low count, 1 to 31.
// - Read strobe high between strobes lasts at least read-low plus read-off.
// - Address/command select is stable read-setup cycles before read strobe falls.
// - Address/command select stays unchanged hold cycles after read strobe rises.
// - Read data sampled at strobe rise; panel access must fit count minus 30 ns.
// - Chip select asserted read-low plus read-setup cycles before read strobe rises.
// - Chip select stays asserted read-off cycles after read strobe rises.
module dbi_panel_strobe_timing
  import dbi_strobe_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic req_dc,
  input wire logic [DATA_W-1:0] req_data,
  input wire logic [COUNT_W-1:0] write_strobe_low_count,
  input wire logic [COUNT_W-1:0] write_setup_count,
  input wire logic [COUNT_W-1:0] shared_hold_count,
  input wire logic [COUNT_W-1:0] read_strobe_low_count,
  input wire logic [COUNT_W-1:0] read_setup_count,
  input wire logic [COUNT_W-1:0] read_off_count,
  output logic cs_n,
  output logic dc,
  output logic wr_n,
  output logic rd_n,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe_n,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid,
  output logic busy,
  output logic read_access_ok
);
  phase_t state_reg;
  phase_t state_next;
  logic [COUNT_W-1:0] cfg_raw [NUM_FIELDS];
  logic [COUNT_W-1:0] cfg_eff [NUM_FIELDS];
  logic [COUNT_W-1:0] cfg_reg [NUM_FIELDS];
  logic is_write_reg;
  logic cs_n_reg, cs_n_next;
  logic dc_reg, dc_next;
  logic wr_n_reg, wr_n_next;
  logic rd_n_reg, rd_n_next;
  logic oe_n_reg, oe_n_next;
  logic [DATA_W-1:0] wdata_reg;
  logic start;
  logic phase_clear;
  logic phase_last;
  logic [PHASE_W-1:0] phase_cnt;
  logic [PHASE_W-1:0] phase_target;
  logic [PHASE_W-1:0] wrc_w, wsc_w, dhc_w, rac_w, rsc_w, roc_w;
  logic [PHASE_W-1:0] rd_sum;
  logic [PHASE_W-1:0] rd_rest;
  logic [PHASE_W-1:0] rd_tail_a;
  logic [PHASE_W-1:0] rd_tail;
  logic in_setup, in_strobe, in_hold, in_idle;
  logic going_idle;
  logic read_sample;
  logic cs_read_release;

  assign cfg_raw[F_WR_LOW] = write_strobe_low_count;
  assign cfg_raw[F_WR_SETUP] = write_setup_count;
  assign cfg_raw[F_HOLD] = shared_hold_count;
  assign cfg_raw[F_RD_LOW] = read_strobe_low_count;
  assign cfg_raw[F_RD_SETUP] = read_setup_count;
  assign cfg_raw[F_RD_OFF] = read_off_count;

  for (genvar i = 0; i < NUM_FIELDS; i++) begin : g_cfg
    assign cfg_eff[i] = (cfg_raw[i] == COUNT_ZERO) ? COUNT_MIN : cfg_raw[i];
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        cfg_reg[i] <= COUNT_MIN;
      end else if (start) begin
        cfg_reg[i] <= cfg_eff[i];
      end
    end
  end

  assign wrc_w = {1'b0, cfg_reg[F_WR_LOW]};
  assign wsc_w = {1'b0, cfg_reg[F_WR_SETUP]};
  assign dhc_w = {1'b0, cfg_reg[F_HOLD]};
  assign rac_w = {1'b0, cfg_reg[F_RD_LOW]};
  assign rsc_w = {1'b0, cfg_reg[F_RD_SETUP]};
  assign roc_w = {1'b0, cfg_reg[F_RD_OFF]};

  // read tail plus the next read setup keeps strobe high at least read-low plus read-off
  assign rd_sum = rac_w + roc_w;
  assign rd_rest = (rd_sum > rsc_w) ? rd_sum - rsc_w : PHASE_ONE;
  assign rd_tail_a = (dhc_w > roc_w) ? dhc_w : roc_w;
  assign rd_tail = (rd_tail_a > rd_rest) ? rd_tail_a : rd_rest;

  assign in_idle = (state_reg == ST_IDLE);
  assign in_setup = (state_reg == ST_SETUP);
  assign in_strobe = (state_reg == ST_STROBE);
  assign in_hold = (state_reg == ST_HOLD);

  // next cycle may start in the last hold cycle
  assign req_ready = in_idle | (in_hold & phase_last);
  assign start = req_valid & req_ready;
  assign going_idle = in_hold & phase_last & ~start;
  assign busy = ~in_idle;

  assign phase_target = in_setup ? (is_write_reg ? wsc_w : rsc_w) :
                        in_strobe ? (is_write_reg ? wrc_w : rac_w) :
                        in_hold ? (is_write_reg ? dhc_w : rd_tail) : PHASE_MAX;
  assign phase_clear = start | ((in_setup | in_strobe) & phase_last);

  phase_counter u_phase (
    .clk(clk),
    .rst_n(rst_n),
    .clear(phase_clear),
    .target(phase_target),
    .count(phase_cnt),
    .last(phase_last)
  );

  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      ST_IDLE: begin
        if (start) begin
          state_next = ST_SETUP;
        end
      end
      ST_SETUP: begin
        if (phase_last) begin
          state_next = ST_STROBE;
        end
      end
      ST_STROBE: begin
        if (phase_last) begin
          state_next = ST_HOLD;
        end
      end
      ST_HOLD: begin
        if (phase_last) begin
          state_next = start ? ST_SETUP : ST_IDLE;
        end
      end
    endcase
  end

  // strobes low for the whole strobe phase
  assign wr_n_next = (in_setup & phase_last) ? ~is_write_reg :
                     (in_strobe & phase_last) ? 1'b1 : wr_n_reg;
  assign rd_n_next = (in_setup & phase_last) ? is_write_reg :
                     (in_strobe & phase_last) ? 1'b1 : rd_n_reg;
  // chip select released after read-off cycles
  assign cs_read_release = in_hold & ~is_write_reg & (phase_cnt == roc_w);
  // chip select spans setup, strobe and write hold; reads release it read-off cycles into hold
  assign cs_n_next = start ? 1'b0 : going_idle ? 1'b1 :
                     cs_read_release ? 1'b1 : cs_n_reg;
  // select changes only when a cycle starts
  assign dc_next = start ? req_dc : dc_reg;
  // data driven from the start of a write
  assign oe_n_next = start ? ~req_write : going_idle ? 1'b1 : oe_n_reg;
  // sample on the edge that raises the read strobe
  assign read_sample = in_strobe & phase_last & ~is_write_reg;
  assign read_access_ok = cfg_eff[F_RD_LOW] > READ_MARGIN_CYC_W;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      cs_n_reg <= CS_N_RST;
      wr_n_reg <= WR_N_RST;
      rd_n_reg <= RD_N_RST;
      oe_n_reg <= OE_N_RST;
      dc_reg <= DC_RST;
    end else begin
      state_reg <= state_next;
      cs_n_reg <= cs_n_next;
      wr_n_reg <= wr_n_next;
      rd_n_reg <= rd_n_next;
      oe_n_reg <= oe_n_next;
      dc_reg <= dc_next;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      is_write_reg <= 1'b0;
      wdata_reg <= '0;
    end else if (start) begin
      is_write_reg <= req_write;
      wdata_reg <= req_data;
    end
  end

  read_capture #(
    .DATA_W(DATA_W)
  ) u_capture (
    .clk(clk),
    .rst_n(rst_n),
    .sample(read_sample),
    .data_in(data_in),
    .rd_data(rd_data),
    .rd_valid(rd_valid)
  );

  assign cs_n = cs_n_reg;
  assign dc = dc_reg;
  assign wr_n = wr_n_reg;
  assign rd_n = rd_n_reg;
  assign data_out = wdata_reg;
  assign data_oe_n = oe_n_reg;

  // Checking helpers: strobe low run and age since cycle start
  logic [PHASE_W-1:0] low_run_reg;
  logic [PHASE_W-1:0] age_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      low_run_reg <= PHASE_RST;
      age_reg <= PHASE_RST;
    end else begin
      low_run_reg <= (wr_n_next & rd_n_next) ? PHASE_RST :
                     (low_run_reg == PHASE_MAX) ? low_run_reg : low_run_reg + PHASE_ONE;
      age_reg <= start ? PHASE_ONE : (age_reg == PHASE_MAX) ? age_reg : age_reg + PHASE_ONE;
    end
  end

  // Checking helpers: strobe high run and the gap owed by the cycle a start ends
  logic [PHASE_W-1:0] high_run_reg;
  logic [PHASE_W-1:0] gap_hold_reg;
  logic [PHASE_W-1:0] gap_read_reg;
  logic gap_wr_reg;
  logic gap_rd_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      high_run_reg <= PHASE_RST;
      gap_hold_reg <= PHASE_RST;
      gap_read_reg <= PHASE_RST;
      gap_wr_reg <= 1'b0;
      gap_rd_reg <= 1'b0;
    end else begin
      high_run_reg <= !(wr_n_next & rd_n_next) ? PHASE_RST :
                      (high_run_reg == PHASE_MAX) ? high_run_reg : high_run_reg + PHASE_ONE;
      if (start) begin
        gap_hold_reg <= dhc_w;
        gap_read_reg <= rd_sum;
        gap_wr_reg <= in_hold & is_write_reg & req_write;
        gap_rd_reg <= in_hold & ~is_write_reg & ~req_write;
      end
    end
  end

  // write strobe gap between back-to-back writes
  a_wr_high_gap: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(wr_n_reg) && gap_wr_reg |-> $past(high_run_reg) == gap_hold_reg + wsc_w)
    else $error("write strobe gap wrong");
  // read strobe gap between back-to-back reads
  a_rd_high_gap: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rd_n_reg) && gap_rd_reg |-> $past(high_run_reg) >= gap_read_reg)
    else $error("read strobe gap too short");
  // pins released when no cycle runs
  a_idle_pins: assert property (@(posedge clk) disable iff (!rst_n)
    in_idle |-> cs_n_reg && oe_n_reg && wr_n_reg && rd_n_reg)
    else $error("pins not released in idle");
  // read data valid only after a read strobe
  a_rd_valid_src: assert property (@(posedge clk) disable iff (!rst_n)
    rd_valid |-> $rose(rd_n_reg) && !is_write_reg)
    else $error("read data valid without read");

  a_wr_low_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wr_n_reg) |-> $past(low_run_reg) == wrc_w) else $error("write strobe width wrong");
  a_rd_low_width: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rd_n_reg) |-> $past(low_run_reg) == rac_w) else $error("read strobe width wrong");
  a_wr_setup_age: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(wr_n_reg) |-> age_reg == wsc_w + PHASE_ONE && $stable(dc_reg) && !cs_n_reg)
    else $error("write setup length wrong");
  a_wr_data_lead: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(wr_n_reg) |-> age_reg == wsc_w + wrc_w + PHASE_ONE && !oe_n_reg && !cs_n_reg)
    else $error("write data lead wrong");
  a_rd_setup_age: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(rd_n_reg) |-> age_reg == rsc_w + PHASE_ONE && $stable(dc_reg) && !cs_n_reg)
    else $error("read setup length wrong");
  a_rd_cs_lead: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rd_n_reg) |-> age_reg == rsc_w + rac_w + PHASE_ONE && !cs_n_reg && oe_n_reg)
    else $error("read chip select lead wrong");
  a_wr_hold_pins: assert property (@(posedge clk) disable iff (!rst_n)
    in_hold && is_write_reg |-> !cs_n_reg && !oe_n_reg && $stable(dc_reg) &&
    $stable(wdata_reg) && phase_cnt <= dhc_w) else $error("write hold broken");
  a_rd_cs_off: assert property (@(posedge clk) disable iff (!rst_n)
    in_hold && !is_write_reg |-> cs_n_reg == (phase_cnt > roc_w) && $stable(dc_reg))
    else $error("read chip select hold wrong");
  a_rd_sample: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(rd_n_reg) |-> rd_valid && rd_data == $past(data_in)) else $error("read sample missed");
endmodule : dbi_panel_strobe_timing

// File: verilog/dbi_strobe_pkg.sv
// Constants, types and reset values shared by the panel strobe timing design
package dbi_strobe_pkg;
  localparam int COUNT_W = 5;
  localparam int PHASE_W = 6;
  localparam int DATA_W_DEFAULT = 16;
  localparam int NUM_FIELDS = 6;
  // Field index of each configuration count
  localparam int F_WR_LOW = 0;
  localparam int F_WR_SETUP = 1;
  localparam int F_HOLD = 2;
  localparam int F_RD_LOW = 3;
  localparam int F_RD_SETUP = 4;
  localparam int F_RD_OFF = 5;
  localparam logic [COUNT_W-1:0] COUNT_ZERO = 5'h00;
  localparam logic [COUNT_W-1:0] COUNT_MIN = 5'h01;
  localparam logic [PHASE_W-1:0] PHASE_ONE = 6'h01;
  localparam logic [PHASE_W-1:0] PHASE_MAX = 6'h3f;
  localparam logic [PHASE_W-1:0] PHASE_RST = 6'h00;
  // Read sampling margin
  localparam int CLK_PERIOD_PS = 5000;
  localparam int READ_MARGIN_NS = 30;
  localparam int READ_MARGIN_CYC = (READ_MARGIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [COUNT_W-1:0] READ_MARGIN_CYC_W = COUNT_W'(READ_MARGIN_CYC);
  // Pin levels after reset
  localparam logic CS_N_RST = 1'b1;
  localparam logic WR_N_RST = 1'b1;
  localparam logic RD_N_RST = 1'b1;
  localparam logic OE_N_RST = 1'b1;
  localparam logic DC_RST = 1'b0;
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_SETUP = 4'b0010,
    ST_STROBE = 4'b0100,
    ST_HOLD = 4'b1000
  } phase_t;
endpackage : dbi_strobe_pkg

// File: verilog/phase_counter.sv
// Up counter that measures the length of one bus phase
module phase_counter
  import dbi_strobe_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [PHASE_W-1:0] target,
  output logic [PHASE_W-1:0] count,
  output logic last
);
  logic [PHASE_W-1:0] count_reg;
  logic [PHASE_W-1:0] count_next;

  assign count_next = clear ? PHASE_ONE : (count_reg == PHASE_MAX) ? count_reg :
                      count_reg + PHASE_ONE;
  assign count = count_reg;
  assign last = (count_reg == target);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= PHASE_RST;
    end else begin
      count_reg <= count_next;
    end
  end
endmodule : phase_counter

// File: verilog/read_capture.sv
// Register that takes the panel read data at the read strobe rising edge
module read_capture
  import dbi_strobe_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEFAULT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sample,
  input wire logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] rd_data,
  output logic rd_valid
);
  logic [DATA_W-1:0] data_reg;
  logic valid_reg;

  assign rd_data = data_reg;
  assign rd_valid = valid_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= '0;
      valid_reg <= 1'b0;
    end else begin
      valid_reg <= sample;
      if (sample) begin
        data_reg <= data_in;
      end
    end
  end
endmodule : read_capture

// File: verif/dbi_panel_model.sv
// Behavioural display panel on the far side of the parallel command bus
module dbi_panel_model
  import dbi_strobe_pkg::*;
#(
  parameter int DATA_W = DATA_W_DEFAULT,
  parameter int ACC_NS = 7
) (
  input wire logic cs_n,
  input wire logic dc,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic [DATA_W-1:0] data_out,
  output logic [DATA_W-1:0] data_in,
  output logic [DATA_W-1:0] last_wr,
  output logic last_dc
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    data_in = '0;
    last_wr = '0;
    last_dc = 1'b0;
  end
  // Latch written word at strobe rise
  always @(posedge wr_n) begin
    if (!cs_n) begin
      last_wr = data_out;
      last_dc = dc;
    end
  end
  always @(negedge rd_n) begin
    #(ACC_NS);
    if (!rd_n && !cs_n) begin
      data_in = {<<8{last_wr}};
    end
  end
  // Released bus shows inverse of last value
  always @(posedge rd_n) begin
    data_in = ~data_in;
  end
endmodule : dbi_panel_model

// File: verif/testbench.sv
// Self-checking bench for the panel strobe sequencer
module testbench
  import dbi_strobe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, req_valid, req_write, req_dc;
  logic [15:0] req_data;
  logic [4:0] cw_l, cw_s, c_h, cr_l, cr_s, cr_o;
  logic req_ready, cs_n, dc, wr_n, rd_n, data_oe_n, rd_valid, busy, read_access_ok, last_dc;
  logic [15:0] data_out, data_in, rd_data, last_wr, dat_q;
  logic dc_q;
  wire stb = wr_n & rd_n;
  int n_fail, comparisons, c_cs, c_lo, c_hi, c_dc, c_dat;
  int setup_cs, dc_len, lo_len, rise_cs, dat_len, post, hi_len, dc_hold, dat_hold;
  dbi_panel_strobe_timing i_dbi_panel_strobe_timing (.clk(clk), .rst_n(rst_n),
    .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write), .req_dc(req_dc),
    .req_data(req_data), .write_strobe_low_count(cw_l), .write_setup_count(cw_s),
    .shared_hold_count(c_h), .read_strobe_low_count(cr_l), .read_setup_count(cr_s),
    .read_off_count(cr_o), .cs_n(cs_n), .dc(dc), .wr_n(wr_n), .rd_n(rd_n),
    .data_out(data_out), .data_oe_n(data_oe_n), .data_in(data_in), .rd_data(rd_data),
    .rd_valid(rd_valid), .busy(busy), .read_access_ok(read_access_ok));
  dbi_panel_model i_dbi_panel_model (.cs_n(cs_n), .dc(dc), .wr_n(wr_n), .rd_n(rd_n),
    .data_out(data_out), .data_in(data_in), .last_wr(last_wr), .last_dc(last_dc));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Interval measurement on the panel pins
  always @(posedge clk) begin
    c_cs <= cs_n ? 0 : c_cs + 1;
    c_lo <= stb ? 0 : c_lo + 1;
    c_hi <= stb ? c_hi + 1 : 0;
    c_dc <= (dc === dc_q) ? c_dc + 1 : 1;
    c_dat <= data_oe_n ? 0 : ((data_out === dat_q) ? c_dat + 1 : 1);
    dc_q <= dc;
    dat_q <= data_out;
    if (!stb && c_lo == 0) begin
      setup_cs <= c_cs;
      dc_len <= c_dc;
      hi_len <= c_hi;
    end
    if (stb && c_lo > 0) begin
      lo_len <= c_lo;
      rise_cs <= c_cs;
      dat_len <= c_dat;
    end
    if (cs_n && c_cs > 0) post <= c_hi;
    if (dc !== dc_q && !cs_n) dc_hold <= c_hi;
    if (data_out !== dat_q && !data_oe_n) dat_hold <= c_hi;
  end
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic close_out;
    $display("Counts: comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : close_out
  function automatic logic [15:0] cl(input logic [4:0] x);
    return (x == 5'h00) ? 16'h0001 : 16'(x);
  endfunction : cl
  task automatic cfg(input logic [4:0] wl, ws, h, rl, rs, ro);
    @(negedge clk);
    {cw_l, cw_s, c_h, cr_l, cr_s, cr_o} = {wl, ws, h, rl, rs, ro};
  endtask : cfg
  task automatic issue(input logic w, input logic d, input logic [15:0] v);
    int k;
    @(negedge clk);
    {req_valid, req_write, req_dc, req_data} = {1'b1, w, d, v};
    k = 0;
    while (req_ready !== 1'b1 && k < 200) begin
      @(negedge clk);
      k++;
    end
    chk("req ready", 16'(req_ready), 16'h0001);
    @(posedge clk);
  endtask : issue
  task automatic idle;
    int k;
    @(negedge clk);
    req_valid = 1'b0;
    k = 0;
    while (busy !== 1'b0 && k < 300) begin
      @(negedge clk);
      k++;
    end
    chk("back to idle", 16'(busy), 16'h0000);
    repeat (2) @(negedge clk);
  endtask : idle
  task automatic test_write(input logic [4:0] s, l, h, input logic d, input logic [15:0] v);
    cfg(l, s, h, 5'h01, 5'h01, 5'h01);
    issue(1'b1, d, v);
    cfg(5'h09, 5'h09, 5'h09, 5'h09, 5'h09, 5'h09);
    idle;
    chk("wr cs setup", 16'(setup_cs), cl(s));
    chk("wr dc setup", 16'(dc_len), cl(s));
    chk("wr low", 16'(lo_len), cl(l));
    chk("wr cs before rise", 16'(rise_cs), cl(s) + cl(l));
    chk("wr data before rise", 16'(dat_len), cl(s) + cl(l));
    chk("wr cs hold", 16'(post), cl(h));
    chk("wr word", last_wr, v);
    chk("wr dc", 16'(last_dc), 16'(d));
    $display("test_write done");
  endtask : test_write
  task automatic test_wr_b2b;
    cfg(5'h01, 5'h03, 5'h02, 5'h01, 5'h01, 5'h01);
    issue(1'b1, 1'b1, 16'h0f0f);
    issue(1'b1, 1'b0, 16'h12ab);
    idle;
    chk("wr high", 16'(hi_len), 16'h0005);
    chk("wr dc hold", 16'(dc_hold), 16'h0002);
    chk("wr data hold", 16'(dat_hold), 16'h0002);
    chk("wr word 2", last_wr, 16'h12ab);
    $display("test_wr_b2b done");
  endtask : test_wr_b2b
  task automatic test_reset_mid;
    cfg(5'h03, 5'h02, 5'h02, 5'h01, 5'h01, 5'h01);
    issue(1'b1, 1'b1, 16'hc3c3);
    @(negedge clk);
    req_valid = 1'b0;
    repeat (3) @(negedge clk);
    chk("mid strobe", 16'({cs_n, wr_n}), 16'h0000);
    rst_n = 1'b0;
    @(negedge clk);
    chk("mid reset pins", 16'({cs_n, wr_n, rd_n, data_oe_n, dc}),
      16'({CS_N_RST, WR_N_RST, RD_N_RST, OE_N_RST, DC_RST}));
    chk("mid reset state", 16'({req_ready, busy, rd_valid}), 16'h0004);
    chk("mid reset data", data_out, 16'h0000);
    rst_n = 1'b1;
    @(negedge clk);
    chk("after reset idle", 16'({cs_n, busy}), 16'h0002);
    $display("test_reset_mid done");
  endtask : test_reset_mid
  task automatic test_read(input logic [4:0] s, l, o, h, input logic d);
    int k;
    cfg(5'h01, 5'h01, h, l, s, o);
    issue(1'b0, d, 16'h0000);
    k = 0;
    while (rd_valid !== 1'b1 && k < 100) begin
      @(negedge clk);
      k++;
    end
    chk("rd valid", 16'(rd_valid), 16'h0001);
    chk("rd data", rd_data, 16'hab12);
    chk("rd bus released", 16'(data_oe_n), 16'h0001);
    idle;
    chk("rd cs setup", 16'(setup_cs), cl(s));
    chk("rd dc setup", 16'(dc_len), cl(s));
    chk("rd low", 16'(lo_len), cl(l));
    chk("rd cs before rise", 16'(rise_cs), cl(s) + cl(l));
    chk("rd cs hold", 16'(post), cl(o));
    chk("rd access ok", 16'(read_access_ok), 16'(l > 5'h06));
    $display("test_read done");
  endtask : test_read
  task automatic test_rd_b2b;
    cfg(5'h01, 5'h01, 5'h01, 5'h03, 5'h02, 5'h02);
    issue(1'b0, 1'b1, 16'h0000);
    issue(1'b0, 1'b0, 16'h0000);
    idle;
    // Tail max(1, 2, 3 + 2 - 2) = 3 plus setup 2
    chk("rd high", 16'(hi_len), 16'h0005);
    chk("rd dc hold", 16'(dc_hold), 16'h0003);
    $display("test_rd_b2b done");
  endtask : test_rd_b2b
  initial begin
    repeat (8000) @(posedge clk);
    n_fail++;
    $display("[ERR] timeout expected done seen hang");
    close_out;
  end
  initial begin
    {rst_n, req_valid, req_write, req_dc, req_data} = '0;
    {cw_l, cw_s, c_h, cr_l, cr_s, cr_o} = {6{5'h01}};
    {c_cs, c_lo, c_hi, c_dc, c_dat, dc_q, dat_q} = '0;
    repeat (4) @(negedge clk);
    chk("reset pins", 16'({cs_n, wr_n, rd_n, data_oe_n, dc}),
      16'({CS_N_RST, WR_N_RST, RD_N_RST, OE_N_RST, DC_RST}));
    chk("reset handshake", 16'({req_ready, busy}), 16'h0002);
    rst_n = 1'b1;
    test_write(5'h02, 5'h03, 5'h02, 1'b1, 16'h1234);
    test_write(5'h1f, 5'h1f, 5'h1f, 1'b0, 16'hbeef);
    test_write(5'h00, 5'h00, 5'h00, 1'b1, 16'h5a5a);
    test_reset_mid;
    test_wr_b2b;
    test_read(5'h02, 5'h06, 5'h03, 5'h02, 1'b1);
    test_read(5'h01, 5'h07, 5'h01, 5'h01, 1'b0);
    test_read(5'h00, 5'h07, 5'h00, 5'h00, 1'b1);
    test_rd_b2b;
    close_out;
  end
endmodule : testbench
